// ---- design/dpdc_pkg.sv ----
// Package for the dual prescaled down counters: register indices,
// field layouts, reset values and timing constants.
// Assumes a 32-bit AXI4-Lite register bus; byte address = 4 * index.

package dpdc_pkg;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W   = 10;
   localparam logic [7:0]  IDX_TMR  = 8'hf1;
   localparam logic [7:0]  IDX_CNT1 = 8'hf2;
   localparam logic [7:0]  IDX_DIV1 = 8'hf3;
   localparam logic [7:0]  IDX_CNT0 = 8'hf4;
   localparam logic [7:0]  IDX_DIV0 = 8'hf5;
   localparam logic [7:0]  IDX_SRC  = 8'hfa;
   localparam logic [7:0]  IDX_STAT = 8'hfb;
   localparam logic [7:0]  IDX_MASK = 8'hfc;

   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [7:0]  TMR_RESET  = 8'h00;
   localparam logic [7:0]  DIV_RESET  = 8'h02;
   localparam logic [7:0]  SRC_RESET  = 8'h00;
   localparam logic [7:0]  CNT_RESET  = 8'h00;
   localparam logic [1:0]  MASK_RESET = 2'h0;
   localparam int unsigned INT_DIV    = 4;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      OUT_FIRST  = 2'b00,
      OUT_SECOND = 2'b01,
      OUT_CLOCK  = 2'b10,
      OUT_OFF    = 2'b11
   } dpdc_out_e;

   typedef enum logic [1:0] {
      PIN_CLOCK  = 2'b00,
      PIN_GATE   = 2'b01,
      PIN_TRIG   = 2'b10,
      PIN_RETRIG = 2'b11
   } dpdc_pin_e;

   typedef struct packed {
      logic [1:0] spare;
      dpdc_out_e  out_sel;
      logic       run1;
      logic       load1;
      logic       run0;
      logic       load0;
   } dpdc_tmr_s;

   typedef struct packed {
      logic [5:0] divide;
      logic       int_clk;
      logic       continuous;
   } dpdc_div_s;

   typedef struct packed {
      logic [4:0] spare;
      logic       cascade;
      dpdc_pin_e  pin_mode;
   } dpdc_src_s;

endpackage : dpdc_pkg

// ---- design/dpdc_top.sv ----
// Two 8-bit down counters with 6-bit prescalers, AXI4-Lite slave,
// sticky interrupt status, timer output pin and external timer input.
// Assumes one clock (aclk); timer_input_pin is asynchronous.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module dpdc_top (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write
   input  wire logic [dpdc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   // AXI4-Lite read
   input  wire logic [dpdc_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   // Pins and interrupts
   input  wire logic                       timer_input_pin,
   output logic                            timer_output_pin,
   output logic                            first_timer_interrupt,
   output logic                            second_timer_interrupt,
   output logic                            irq
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   dpdc_pkg::dpdc_tmr_s        tmr;
   dpdc_pkg::dpdc_div_s        div [2];
   dpdc_pkg::dpdc_src_s        src;
   logic [1:0]                 stat;
   logic [1:0]                 mask;
   logic [7:0]                 count [2];
   logic [7:0]                 init [2];
   logic [5:0]                 presc [2];
   logic [1:0]                 run;
   logic [1:0]                 eoc;
   logic [1:0]                 ptick;
   logic [1:0]                 src_en;
   logic [1:0]                 load_req;
   logic [1:0]                 run_wr;
   logic [1:0]                 cnt_wr;
   logic [1:0]                 trig_start;
   logic [1:0]                 toggle;
   logic [1:0]                 quarter;
   logic                       int_tick;
   logic                       pin_meta;
   logic                       pin_sync;
   logic                       pin_prev;
   logic                       pin_rise;
   logic                       aw_hold;
   logic                       w_hold;
   logic [dpdc_pkg::ADDR_W-1:0] aw_addr;
   logic [7:0]                 w_data;
   logic                       w_lane;
   logic                       wr_go;
   logic                       wr_en;
   logic                       wr_hit;
   logic [7:0]                 wr_idx;
   logic [7:0]                 rd_idx;
   logic [7:0]                 rd_data;
   logic                       rd_hit;
   logic                       ar_take;
   logic                       stat_rd;

   // ------------------------------------------------------------------
   // Input pin synchroniser and internal clock divider
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= timer_input_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Edges are only seen if the source holds each level a clock or more
   assign pin_rise = pin_sync & ~pin_prev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quarter <= 2'h0;
      end else begin
         quarter <= quarter + 2'h1;
      end
   end

   assign int_tick = (quarter == 2'(dpdc_pkg::INT_DIV - 1));

   // ------------------------------------------------------------------
   // Prescaler sources and triggers
   // ------------------------------------------------------------------
   always_comb begin
      src_en[0]     = int_tick;
      trig_start[0] = 1'b0;
      trig_start[1] = 1'b0;
      if (src.cascade) begin
         src_en[1] = eoc[0];
      end else if (!div[1].int_clk) begin
         src_en[1] = pin_rise;
      end else begin
         src_en[1] = int_tick & ((src.pin_mode != dpdc_pkg::PIN_GATE) | pin_sync);
         if (src.pin_mode == dpdc_pkg::PIN_TRIG) begin
            trig_start[1] = pin_rise & ~run[1];
         end else if (src.pin_mode == dpdc_pkg::PIN_RETRIG) begin
            trig_start[1] = pin_rise;
         end
      end
   end

   // ------------------------------------------------------------------
   // Bus decode helpers
   // ------------------------------------------------------------------
   assign wr_go  = aw_hold & w_hold & ~bvalid;
   assign wr_idx = aw_addr[dpdc_pkg::ADDR_W-1:2];
   assign wr_hit = (aw_addr[1:0] == 2'h0) &&
                   ((wr_idx >= dpdc_pkg::IDX_TMR && wr_idx <= dpdc_pkg::IDX_DIV0) ||
                    (wr_idx >= dpdc_pkg::IDX_SRC && wr_idx <= dpdc_pkg::IDX_MASK));
   assign wr_en  = wr_go & wr_hit & w_lane;
   assign ar_take = arvalid & arready;
   assign rd_idx  = araddr[dpdc_pkg::ADDR_W-1:2];
   assign stat_rd = ar_take && rd_hit && (rd_idx == dpdc_pkg::IDX_STAT);

   always_comb begin
      load_req[0] = wr_en && (wr_idx == dpdc_pkg::IDX_TMR) && w_data[0];
      load_req[1] = (wr_en && (wr_idx == dpdc_pkg::IDX_TMR) && w_data[2]) || trig_start[1];
      run_wr[0]   = wr_en && (wr_idx == dpdc_pkg::IDX_TMR);
      run_wr[1]   = run_wr[0];
      cnt_wr[0]   = wr_en && (wr_idx == dpdc_pkg::IDX_CNT0);
      cnt_wr[1]   = wr_en && (wr_idx == dpdc_pkg::IDX_CNT1);
   end

   // ------------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------------
   // Loading and the running flag are the same write, so a mode write
   // with load and run set restarts from the initial value in one step.
   for (genvar i = 0; i < 2; i++) begin : g_timer
      assign ptick[i] = src_en[i] & run[i] & (presc[i] == 6'h00);

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            presc[i] <= 6'h3f;
            count[i] <= dpdc_pkg::CNT_RESET;
            init[i]  <= dpdc_pkg::CNT_RESET;
            run[i]   <= 1'b0;
            eoc[i]   <= 1'b0;
         end else begin
            eoc[i] <= 1'b0;
            if (cnt_wr[i]) begin
               init[i] <= w_data;
            end
            if (load_req[i]) begin
               count[i] <= init[i];
               presc[i] <= div[i].divide - 6'h01;
            end else if (cnt_wr[i] && !run[i]) begin
               count[i] <= w_data;
            end else if (ptick[i]) begin
               presc[i] <= div[i].divide - 6'h01;
               if (count[i] == 8'h01) begin
                  eoc[i] <= 1'b1;
                  count[i] <= div[i].continuous ? init[i] : 8'h00;
               end else begin
                  count[i] <= count[i] - 8'h01;
               end
            end else if (src_en[i] && run[i]) begin
               presc[i] <= presc[i] - 6'h01;
            end
            if (trig_start[i]) begin
               run[i] <= 1'b1;
            end else if (run_wr[i]) begin
               run[i] <= (i == 0) ? w_data[1] : w_data[3];
            end else if (ptick[i] && count[i] == 8'h01 && !div[i].continuous) begin
               run[i] <= 1'b0;
            end
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            toggle[i] <= 1'b0;
         end else if (eoc[i]) begin
            toggle[i] <= ~toggle[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr    <= dpdc_pkg::TMR_RESET;
         div[0] <= dpdc_pkg::DIV_RESET;
         div[1] <= dpdc_pkg::DIV_RESET;
         src    <= dpdc_pkg::SRC_RESET;
         mask   <= dpdc_pkg::MASK_RESET;
      end else if (wr_en) begin
         if (wr_idx == dpdc_pkg::IDX_TMR) begin
            tmr <= w_data;
         end else if (wr_idx == dpdc_pkg::IDX_DIV1) begin
            div[1] <= w_data;
         end else if (wr_idx == dpdc_pkg::IDX_DIV0) begin
            div[0] <= w_data;
         end else if (wr_idx == dpdc_pkg::IDX_SRC) begin
            src <= w_data;
         end else if (wr_idx == dpdc_pkg::IDX_MASK) begin
            mask <= w_data[1:0];
         end
      end
   end

   // Set beats the clearing read so an end of count is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat <= 2'h0;
      end else begin
         stat <= eoc | (stat & ~{2{stat_rd}});
      end
   end

   // ------------------------------------------------------------------
   // Pin and interrupt outputs
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_output_pin       <= 1'b0;
         first_timer_interrupt  <= 1'b0;
         second_timer_interrupt <= 1'b0;
         irq                    <= 1'b0;
      end else begin
         case (tmr.out_sel)
            dpdc_pkg::OUT_FIRST:  timer_output_pin <= toggle[0];
            dpdc_pkg::OUT_SECOND: timer_output_pin <= toggle[1];
            dpdc_pkg::OUT_CLOCK:  timer_output_pin <= quarter[1];
            default:              timer_output_pin <= 1'b0;
         endcase
         first_timer_interrupt  <= eoc[0];
         second_timer_interrupt <= eoc[1];
         irq                    <= |(next_stat_masked());
      end
   end

   function automatic logic [1:0] next_stat_masked();
      return (eoc | (stat & ~{2{stat_rd}})) & mask;
   endfunction : next_stat_masked

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 8'h00;
         w_lane  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= dpdc_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold <= 1'b1;
            aw_addr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_hold <= 1'b1;
            w_data <= wdata[7:0];
            w_lane <= wstrb[0];
            wready <= 1'b0;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   always_comb begin
      rd_hit  = (araddr[1:0] == 2'h0);
      rd_data = 8'h00;
      if (rd_idx == dpdc_pkg::IDX_TMR) begin
         rd_data = {tmr.spare, tmr.out_sel, run[1], 1'b0, run[0], 1'b0};
      end else if (rd_idx == dpdc_pkg::IDX_CNT1) begin
         rd_data = count[1];
      end else if (rd_idx == dpdc_pkg::IDX_CNT0) begin
         rd_data = count[0];
      end else if (rd_idx == dpdc_pkg::IDX_DIV1 || rd_idx == dpdc_pkg::IDX_DIV0) begin
         rd_data = 8'h00;
      end else if (rd_idx == dpdc_pkg::IDX_SRC) begin
         rd_data = src;
      end else if (rd_idx == dpdc_pkg::IDX_STAT) begin
         rd_data = {6'h00, stat};
      end else if (rd_idx == dpdc_pkg::IDX_MASK) begin
         rd_data = {6'h00, mask};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= dpdc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h0, rd_hit ? rd_data : 8'h00};
         rresp   <= rd_hit ? dpdc_pkg::RESP_OKAY : dpdc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_int_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      int_tick |=> !int_tick [*3] ##1 int_tick)
      else $error("internal tick not every fourth clock");

   a_eoc_sets_status: assert property (@(posedge aclk) disable iff (!aresetn)
      eoc[0] |=> stat[0] && first_timer_interrupt)
      else $error("first end of count lost");

   a_second_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      eoc[1] |=> second_timer_interrupt && first_timer_interrupt == $past(eoc[0]))
      else $error("second interrupt line wrong");

   a_single_pass: assert property (@(posedge aclk) disable iff (!aresetn)
      ptick[0] && count[0] == 8'h01 && !div[0].continuous && !load_req[0] && !run_wr[0]
      |=> !run[0] && count[0] == 8'h00 && eoc[0])
      else $error("single pass did not halt at zero");

   a_modulo_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      ptick[0] && count[0] == 8'h01 && div[0].continuous && !load_req[0] && !cnt_wr[0]
      && !run_wr[0]
      |=> count[0] == $past(init[0]) && run[0])
      else $error("continuous mode did not reload");

   a_stopped_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      !run[0] && !load_req[0] && !cnt_wr[0] |=> count[0] == $past(count[0]))
      else $error("stopped counter moved");

   a_count_read: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && araddr == {dpdc_pkg::IDX_CNT0, 2'b00}
      |=> rvalid && rdata[7:0] == $past(count[0]) && rresp == dpdc_pkg::RESP_OKAY)
      else $error("counter read wrong");

   a_div_unread: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && araddr == {dpdc_pkg::IDX_DIV0, 2'b00} |=> rdata == 32'h0)
      else $error("prescaler readable");

   a_cascade_tick: assert property (@(posedge aclk) disable iff (!aresetn)
      src.cascade && eoc[0] |-> src_en[1])
      else $error("cascade did not clock second timer");

   a_stopped_write: assert property (@(posedge aclk) disable iff (!aresetn)
      cnt_wr[1] && !run[1] && !load_req[1] |=> init[1] == count[1])
      else $error("stopped write not stored as initial");

endmodule : dpdc_top

`default_nettype wire

// ---- verification/dpdc_pin_source.sv ----
// Far-side source for the timer input pin: bursts of whole pulses.
// Assumes the bench asks for a burst only while busy is low.
`timescale 1ns/1ps
`default_nettype none

module dpdc_pin_source (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Burst request
   input  wire logic       go,
   input  wire logic [3:0] pulses,
   // Pin side
   output logic            pin,
   output logic            busy
);
   logic [4:0] edges_left;
   logic [1:0] hold;

   // Each level stands three clocks, above the one-clock minimum
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin        <= 1'b0;
         edges_left <= 5'h00;
         hold       <= 2'h0;
      end else if (go && edges_left == 5'h00) begin
         edges_left <= {pulses, 1'b0};
         hold       <= 2'h2;
      end else if (edges_left != 5'h00) begin
         if (hold == 2'h0) begin
            pin        <= ~pin;
            edges_left <= edges_left - 5'h01;
            hold       <= 2'h2;
         end else begin
            hold <= hold - 2'h1;
         end
      end
   end

   assign busy = edges_left != 5'h00;
endmodule : dpdc_pin_source

`default_nettype wire

// ---- verification/tb_dual_prescaled_down_counters.sv ----
// Self-checking bench for the dual down counters over AXI4-Lite.
// Assumes dpdc_top and the pin source model; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_dual_prescaled_down_counters;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
   logic        awready, wready, bvalid, arready, rvalid, pin, timer_output, irq0, irq1, irq, busy;
   logic [9:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd, seed;
   logic [3:0]  wstrb, pulses;
   logic [1:0]  bresp, rresp, rsp;
   int          fails, num_checks, cyc, t0, t1, v, d, c;

   dpdc_top dpdc_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .timer_input_pin(pin), .timer_output_pin(timer_output), .first_timer_interrupt(irq0),
      .second_timer_interrupt(irq1), .irq(irq));
   dpdc_pin_source dpdc_pin_source_inst (.aclk(aclk), .aresetn(aresetn), .go(go),
      .pulses(pulses), .pin(pin), .busy(busy));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Ceiling well above the longest timer run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         conclude();
      end
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   function automatic int period(input int n, input int div);
      return n * div * dpdc_pkg::INT_DIV;
   endfunction : period

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk_resp

   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, dat};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awready && !a) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string n);
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd  = rdata;
      rsp = rresp;
      rready <= 1'b0;
      chk(n, {24'h0, e}, rd);
   endtask : rchk

   // Waits up to lim cycles for a pulse on the chosen line
   task automatic wait_int(input logic sel, input logic want, input int lim, output int t);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((sel ? irq1 : irq0) !== 1'b1 && n < lim);
      t = cyc;
      chk("interrupt", {31'h0, want}, {31'h0, sel ? irq1 : irq0});
   endtask : wait_int

   task automatic toggles(input int e);
      int n;
      logic p;
      n = 0;
      // Let a fresh output selection settle before counting edges
      repeat (2) @(posedge aclk);
      p = timer_output;
      repeat (16) begin
         @(posedge aclk);
         n += int'(timer_output !== p);
         p = timer_output;
      end
      chk("output toggles", e, n);
   endtask : toggles

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, go, aresetn} = '0;
      {awaddr, araddr, wdata, pulses, fails, num_checks, cyc} = '0;
      wstrb = 4'h1;
      seed  = 32'd13335;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // ------------------------------------------------------------------
      // Register map and access kinds
      // ------------------------------------------------------------------
      rchk(dpdc_pkg::IDX_TMR, dpdc_pkg::TMR_RESET, "mode");
      rchk(dpdc_pkg::IDX_CNT0, dpdc_pkg::CNT_RESET, "count0");
      seed = xorshift(seed);
      wr(dpdc_pkg::IDX_TMR, 8'hf0);
      chk_resp("bresp", dpdc_pkg::RESP_OKAY, rsp);
      rchk(dpdc_pkg::IDX_TMR, 8'hf0, "mode");
      toggles(0);
      wr(dpdc_pkg::IDX_CNT1, seed[7:0]);
      rchk(dpdc_pkg::IDX_CNT1, seed[7:0], "count1");
      wr(dpdc_pkg::IDX_CNT0, seed[15:8]);
      rchk(dpdc_pkg::IDX_CNT0, seed[15:8], "count0");
      wr(dpdc_pkg::IDX_DIV0, seed[23:16]);
      rchk(dpdc_pkg::IDX_DIV0, 8'h00, "divider0");
      wr(dpdc_pkg::IDX_DIV1, 8'hff);
      rchk(dpdc_pkg::IDX_DIV1, 8'h00, "divider1");
      rchk(8'h80, 8'h00, "unmapped");
      chk_resp("rresp", dpdc_pkg::RESP_SLVERR, rsp);
      wr(8'h80, 8'h5a);
      chk_resp("bresp", dpdc_pkg::RESP_SLVERR, rsp);
      wr(dpdc_pkg::IDX_TMR, 8'h20);
      toggles(8);
      // ------------------------------------------------------------------
      // First timer: corners then random lengths and divisors
      // ------------------------------------------------------------------
      for (int k = 0; k < 5; k++) begin
         seed = xorshift(seed);
         v = k == 0 ? 1 : k == 1 ? 256 : 1 + int'(seed[2:0]);
         d = k == 0 ? 64 : k == 1 ? 1 : 1 + int'(seed[9:8]);
         wr(dpdc_pkg::IDX_MASK, {7'h0, k != 0});
         wr(dpdc_pkg::IDX_DIV0, {d[5:0], 2'b01});
         wr(dpdc_pkg::IDX_CNT0, v[7:0]);
         wr(dpdc_pkg::IDX_TMR, 8'h03);
         wait_int(1'b0, 1'b1, period(v, d) + 16, t0);
         wait_int(1'b0, 1'b1, period(v, d) + 16, t1);
         chk("period", period(v, d), t1 - t0);
         wr(dpdc_pkg::IDX_TMR, 8'h00);
         // With divide 1 one more tick lands while the stop write is in flight
         rchk(dpdc_pkg::IDX_CNT0, 8'((d == 1 && v != 1) ? v - 1 : v), "count0 stop");
         c = rd[7:0] == 8'h00 ? 256 : int'(rd[7:0]);
         repeat (period(2, d)) @(posedge aclk);
         rchk(dpdc_pkg::IDX_CNT0, c[7:0], "count0 frozen");
         wr(dpdc_pkg::IDX_TMR, 8'h02);
         wait_int(1'b0, 1'b1, period(c, d) + 16, t0);
         wr(dpdc_pkg::IDX_DIV0, {d[5:0], 2'b00});
         wr(dpdc_pkg::IDX_TMR, 8'h03);
         wait_int(1'b0, 1'b1, period(v, d) + 16, t0);
         wait_int(1'b0, 1'b0, period(v, d) + 16, t0);
         rchk(dpdc_pkg::IDX_CNT0, 8'h00, "count0 halted");
         chk("irq", {31'h0, k != 0}, {31'h0, irq});
         rchk(dpdc_pkg::IDX_STAT, 8'h01, "status");
         rchk(dpdc_pkg::IDX_STAT, 8'h00, "status cleared");
         chk("irq", 32'h0, {31'h0, irq});
      end
      // ------------------------------------------------------------------
      // Second timer: pin edges, then internal clock divided by four
      // ------------------------------------------------------------------
      wr(dpdc_pkg::IDX_SRC, 8'h00);
      wr(dpdc_pkg::IDX_DIV1, 8'h04);
      wr(dpdc_pkg::IDX_CNT1, 8'h03);
      wr(dpdc_pkg::IDX_TMR, 8'h0c);
      for (int b = 2; b > 0; b--) begin
         @(posedge aclk);
         go     <= 1'b1;
         pulses <= b[3:0];
         @(posedge aclk);
         go <= 1'b0;
         @(posedge aclk);
         while (busy) @(posedge aclk);
         repeat (6) @(posedge aclk);
         rchk(dpdc_pkg::IDX_CNT1, b == 2 ? 8'h01 : 8'h00, "count1 pin");
      end
      rchk(dpdc_pkg::IDX_STAT, 8'h02, "status");
      wr(dpdc_pkg::IDX_DIV1, 8'h07);
      wr(dpdc_pkg::IDX_CNT1, 8'h02);
      wr(dpdc_pkg::IDX_TMR, 8'h0c);
      wait_int(1'b1, 1'b1, 40, t0);
      wait_int(1'b1, 1'b1, 40, t1);
      chk("period1", period(2, 1), t1 - t0);
      // Cascade: three first-timer ends per second-timer end
      wr(dpdc_pkg::IDX_SRC, 8'h04);
      wr(dpdc_pkg::IDX_DIV0, 8'h05);
      wr(dpdc_pkg::IDX_CNT0, 8'h02);
      wr(dpdc_pkg::IDX_DIV1, 8'h05);
      wr(dpdc_pkg::IDX_CNT1, 8'h03);
      wr(dpdc_pkg::IDX_TMR, 8'h0f);
      wait_int(1'b1, 1'b1, 60, t0);
      wait_int(1'b1, 1'b1, 60, t1);
      chk("cascade period", 3 * period(2, 1), t1 - t0);
      toggles(2);
      // Non-retriggerable trigger starts a stopped second timer
      wr(dpdc_pkg::IDX_TMR, 8'h00);
      wr(dpdc_pkg::IDX_SRC, 8'h02);
      wr(dpdc_pkg::IDX_DIV1, 8'h06);
      wr(dpdc_pkg::IDX_CNT1, 8'h02);
      @(posedge aclk);
      go     <= 1'b1;
      pulses <= 4'h1;
      @(posedge aclk);
      go <= 1'b0;
      wait_int(1'b1, 1'b1, 40, t0);
      rchk(dpdc_pkg::IDX_CNT1, 8'h00, "count1 trigger");
      conclude();
   end
endmodule : tb_dual_prescaled_down_counters

`default_nettype wire
